// *** core/aeoc_device.sv ***
// Encoder device end: serial angle output, programming input, one-time store,
// pulse-width output, incremental outputs and status flags.
// Assumes the angle, field magnitude and field flags come from logic on clk.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Quadrature channel high for half a cycle.
// - Four alternating states of 90 degrees each.
// - Channel B centre lags channel A by 90.
// - Cycle is one turn over resolution.
// - Index only in zero cycle, programmable width.
// - Angle code 10 to 16 bits serially.
// - Angle also shown as pulse-width output.
// - Pins carry A/B/index or U/V/W.
// - High flag: strong field, or programming error.
// - Low flag: weak field, or programming done.
// - Alignment select: 0 normal, 1 alignment.
// - Power-down select 1 stops outputs; the status flags keep running.
// - Program enable 1 selects programming mode.
// - Data pin outputs angle, inputs when programming.
// - Host supplies clock and active-low strobe.
// - Serial link supports 3-wire and 2-wire.
// - Zero, direction, index width are programmable.
// - Incremental resolution 8 to 1024 counts.
// - One-time store holds resolution and modes.
// - Slow: 10/16 bits; fast: 10/14 bits.
module aeoc_device (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Link
  aeoc_link_if.device link,
  // Sensor side
  input wire logic [15:0] angleRaw,
  input wire logic [15:0] fieldMag,
  input wire logic fieldHighFlag,
  input wire logic fieldLowFlag,
  // Status
  output logic [25:0] cfgActive,
  output logic powerDown
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pinMeta;
  logic [5:0] pinSync;
  logic [5:0] pinPrev;
  logic strobeN;
  logic sclk;
  logic sdIn;
  logic alignMode;
  logic pdMode;
  logic progMode;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta <= 6'h07;
      pinSync <= 6'h07;
      pinPrev <= 6'h07;
    end else begin
      pinMeta <= {link.programEnableInput, link.powerDownSelect, link.alignSelect,
                  link.serialDataBidir, link.serialClock, link.serialStrobeN};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  assign strobeN = pinSync[0];
  assign sclk = pinSync[1];
  assign sdIn = pinSync[2];
  assign alignMode = pinSync[3];
  assign pdMode = pinSync[4];
  assign progMode = pinSync[5];

  logic strobeFall;
  logic strobeRise;
  logic sclkRise;
  logic sclkFall;
  assign strobeFall = pinPrev[0] && !strobeN;
  assign strobeRise = !pinPrev[0] && strobeN;
  assign sclkRise = !pinPrev[1] && sclk;
  assign sclkFall = pinPrev[1] && !sclk;

  // ----------------------------------------------------------------
  // One-time configuration store
  // ----------------------------------------------------------------
  logic [25:0] progShift;
  logic [5:0] progCnt;
  logic burned;
  logic progDone;
  logic progError;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      progShift <= 26'h0;
      progCnt <= 6'h0;
    end else if (progMode && strobeFall) begin
      progCnt <= 6'h0;
    end else if (progMode && !strobeN && sclkFall) begin
      progShift <= {progShift[24:0], sdIn};
      if (progCnt != 6'h3f) begin
        progCnt <= progCnt + 6'h01;
      end
    end
  end

  // A frame of exactly one word commits once; any later or malformed frame is an error.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgActive <= aeoc_pkg::CFG_RESET;
      burned <= 1'b0;
      progDone <= 1'b0;
      progError <= 1'b0;
    end else if (!progMode) begin
      progDone <= 1'b0;
      progError <= 1'b0;
    end else if (strobeRise) begin
      if (progCnt == 6'(aeoc_pkg::CFG_W) && !burned) begin
        cfgActive <= progShift;
        burned <= 1'b1;
        progDone <= 1'b1;
      end else begin
        progError <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Position correction
  // ----------------------------------------------------------------
  logic dirInvert;
  logic [15:0] zeroPos;
  logic [15:0] posReg;
  logic [15:0] posNext;
  assign dirInvert = cfgActive[aeoc_pkg::CFG_DIR_BIT];
  assign zeroPos = cfgActive[aeoc_pkg::CFG_ZERO_LSB +: 16];
  assign posNext = (dirInvert ? (16'h0000 - angleRaw) : angleRaw) - zeroPos;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      posReg <= 16'h0;
    end else begin
      posReg <= posNext;
    end
  end

  // Keeps the top bits of a left-aligned code for the chosen resolution.
  function automatic logic [15:0] absMask(input logic fast, input logic high);
    logic [15:0] m;
    m = 16'hffc0;
    if (high) begin
      m = fast ? 16'hfffc : 16'hffff;
    end
    return m;
  endfunction

  logic [15:0] absCode;
  assign absCode = posReg & absMask(cfgActive[aeoc_pkg::CFG_FAST_BIT],
                                    cfgActive[aeoc_pkg::CFG_ABSHI_BIT]);

  // ----------------------------------------------------------------
  // Serial angle output
  // ----------------------------------------------------------------
  logic twoWire;
  logic [15:0] txShift;
  logic [11:0] idleCnt;
  logic idleReload;
  assign twoWire = cfgActive[aeoc_pkg::CFG_TWOWIRE_BIT];
  assign idleReload = twoWire && (idleCnt == 12'(aeoc_pkg::FRAME_IDLE_CYC));

  // With the strobe held low in 2-wire mode, a quiet clock marks the frame boundary.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idleCnt <= 12'h0;
    end else if (strobeN || sclkRise || sclkFall) begin
      idleCnt <= 12'h0;
    end else if (idleCnt <= 12'(aeoc_pkg::FRAME_IDLE_CYC)) begin
      idleCnt <= idleCnt + 12'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txShift <= 16'h0;
    end else if ((!twoWire && strobeFall) || idleReload) begin
      txShift <= alignMode ? fieldMag : absCode;
    end else if (!strobeN && sclkRise) begin
      txShift <= {txShift[14:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.sdDevOut <= 1'b0;
      link.sdDevOe <= 1'b0;
    end else begin
      link.sdDevOut <= txShift[15];
      link.sdDevOe <= !strobeN && !progMode && !pdMode;
    end
  end

  // ----------------------------------------------------------------
  // Pulse-width and incremental outputs
  // ----------------------------------------------------------------
  logic [aeoc_pkg::PWM_BITS-1:0] pwmCnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwmCnt <= '0;
      link.pwmOut <= 1'b0;
    end else begin
      pwmCnt <= pwmCnt + 1'b1;
      link.pwmOut <= !pdMode && (pwmCnt < posReg[15 -: aeoc_pkg::PWM_BITS]);
    end
  end

  logic [2:0] incPins;
  aeoc_quad_gen aeoc_quad_gen_inst (
    .clk(clk),
    .rst_n(rst_n),
    .pos(posReg),
    .resSel(cfgActive[aeoc_pkg::CFG_RES_LSB +: 3]),
    .commutationMode(cfgActive[aeoc_pkg::CFG_UVW_BIT]),
    .indexWidth(cfgActive[aeoc_pkg::CFG_IDX_LSB +: 2]),
    .enable(!pdMode && !progMode),
    .chOut(incPins)
  );
  assign link.incA = incPins[0];
  assign link.incB = incPins[1];
  assign link.incI = incPins[2];

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.fieldHighOrProgErrorFlag <= 1'b0;
      link.fieldLowOrProgDoneFlag <= 1'b0;
      powerDown <= 1'b0;
    end else begin
      link.fieldHighOrProgErrorFlag <= progMode ? progError : fieldHighFlag;
      link.fieldLowOrProgDoneFlag <= progMode ? progDone : fieldLowFlag;
      powerDown <= pdMode;
    end
  end
endmodule
`default_nettype wire

// *** core/aeoc_host.sv ***
// Host controller end: makes the link clock and strobe, reads the angle,
// shifts programming words out and drives the mode pins.
// Assumes software on clk using the plain register port.
`timescale 1ns/10ps
`default_nettype none
module aeoc_host (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  // Link
  aeoc_link_if.host link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LEAD = 3'b001,
    H_SHIFT = 3'b010,
    H_TRAIL = 3'b011,
    H_GAP = 3'b100
  } aeoc_hstate_t;

  aeoc_hstate_t state;
  logic [5:0] ctrlBits;
  logic [4:0] nBits;
  logic [25:0] progData;
  logic [15:0] angleReg;
  logic [25:0] txReg;
  logic [15:0] rxReg;
  logic [5:0] bitCnt;
  logic [8:0] cnt;
  logic isProg;
  logic [5:0] inMeta;
  logic [5:0] inSync;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inMeta <= 6'h0;
      inSync <= 6'h0;
    end else begin
      inMeta <= {link.serialDataBidir, link.fieldLowOrProgDoneFlag,
                 link.fieldHighOrProgErrorFlag, link.incI, link.incB, link.incA};
      inSync <= inMeta;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic startRead;
  logic startProg;
  assign startRead = wrEn && addr == aeoc_pkg::REG_CTRL && wrData[aeoc_pkg::CTRL_READ_BIT];
  assign startProg = wrEn && addr == aeoc_pkg::REG_CTRL && wrData[aeoc_pkg::CTRL_PROGRAM_ENABLE_INPUT_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlBits <= 6'h0;
      nBits <= aeoc_pkg::NBITS_RESET;
      progData <= 26'h0;
    end else if (wrEn && addr == aeoc_pkg::REG_CTRL) begin
      ctrlBits <= {wrData[aeoc_pkg::CTRL_TWOWIRE_BIT -: 4], 2'b00};
      nBits <= wrData[aeoc_pkg::CTRL_NBITS_LSB +: 5];
    end else if (wrEn && addr == aeoc_pkg::REG_PROGDATA) begin
      progData <= wrData[25:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 32'h0;
    end else if (rdEn) begin
      unique case (addr)
        aeoc_pkg::REG_CTRL: rdData <= {19'h0, nBits, 2'b00, ctrlBits};
        aeoc_pkg::REG_PROGDATA: rdData <= {6'h0, progData};
        aeoc_pkg::REG_STATUS: rdData <= {26'h0, inSync[4:0], state != H_IDLE};
        aeoc_pkg::REG_ANGLE: rdData <= {16'h0, angleReg};
        default: rdData <= 32'h0;
      endcase
    end
  end

  assign link.alignSelect = ctrlBits[aeoc_pkg::CTRL_ALIGN_BIT];
  assign link.powerDownSelect = ctrlBits[aeoc_pkg::CTRL_PD_BIT];
  assign link.programEnableInput = ctrlBits[aeoc_pkg::CTRL_PEN_BIT];

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  logic twoWire;
  logic tick;
  assign twoWire = ctrlBits[aeoc_pkg::CTRL_TWOWIRE_BIT];
  assign tick = (cnt == 9'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= H_IDLE;
      cnt <= 9'h0;
      bitCnt <= 6'h0;
      isProg <= 1'b0;
      txReg <= 26'h0;
      rxReg <= 16'h0;
      angleReg <= 16'h0;
      link.serialClock <= 1'b1;
      link.serialStrobeN <= 1'b1;
    end else begin
      if (!tick) begin
        cnt <= cnt - 9'h001;
      end
      unique case (state)
        H_IDLE: begin
          link.serialStrobeN <= !twoWire;
          if (startRead || startProg) begin
            isProg <= startProg;
            txReg <= progData;
            bitCnt <= startProg ? 6'(aeoc_pkg::CFG_W) : {1'b0, nBits};
            link.serialStrobeN <= 1'b0;
            cnt <= 9'(aeoc_pkg::HOST_GAP_CYC - 1);
            state <= H_LEAD;
          end
        end
        H_LEAD: begin
          if (tick) begin
            cnt <= 9'(aeoc_pkg::LINK_HALF_CYC - 1);
            state <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick) begin
            cnt <= 9'(aeoc_pkg::LINK_HALF_CYC - 1);
            if (link.serialClock) begin
              link.serialClock <= 1'b0;
              rxReg <= {rxReg[14:0], inSync[5]};
              bitCnt <= bitCnt - 6'h01;
            end else begin
              link.serialClock <= 1'b1;
              txReg <= {txReg[24:0], 1'b0};
              if (bitCnt == 6'h0) begin
                state <= H_TRAIL;
              end
            end
          end
        end
        H_TRAIL: begin
          if (tick) begin
            link.serialStrobeN <= !twoWire || isProg;
            if (!isProg) begin
              angleReg <= rxReg;
            end
            cnt <= 9'(aeoc_pkg::HOST_GAP_CYC - 1);
            state <= H_GAP;
          end
        end
        H_GAP: begin
          if (tick) begin
            state <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  assign link.sdHostOut = txReg[25];
  assign link.sdHostOe = isProg && (state == H_LEAD || state == H_SHIFT);
endmodule
`default_nettype wire

// *** core/aeoc_quad_gen.sv ***
// Incremental output generator: quadrature plus index, or three commutation phases.
// Assumes a position already corrected for zero and direction.
`timescale 1ns/10ps
`default_nettype none
module aeoc_quad_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Position and settings
  input wire logic [15:0] pos,
  input wire logic [2:0] resSel,
  input wire logic commutationMode,
  input wire logic [1:0] indexWidth,
  input wire logic enable,
  // Pins
  output logic [2:0] chOut
);
  logic [15:0] frac;
  logic [1:0] quarter;
  logic cycleZero;
  logic [18:0] sextProd;
  logic [2:0] sext;
  logic [2:0] chNext;

  // Resolution is 8 << resSel counts per turn; frac is the angle inside one cycle.
  assign frac = pos << (5'd3 + {2'b00, resSel});
  assign quarter = frac[15:14];
  assign cycleZero = (pos >> (5'd13 - {2'b00, resSel})) == 16'h0000;
  assign sextProd = {3'h0, frac} * 19'h00006;
  assign sext = sextProd[18:16];

  always_comb begin
    if (commutationMode) begin
      chNext[0] = (sext <= 3'h2);
      chNext[1] = (sext >= 3'h2) && (sext <= 3'h4);
      chNext[2] = (sext >= 3'h4) || (sext == 3'h0);
    end else begin
      chNext[0] = ~quarter[1];
      chNext[1] = quarter[1] ^ quarter[0];
      chNext[2] = cycleZero && (quarter <= indexWidth);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chOut <= 3'h0;
    end else begin
      chOut <= enable ? chNext : 3'h0;
    end
  end
endmodule
`default_nettype wire

// *** inc/aeoc_link_if.sv ***
// Pins between the encoder device and its host controller.
// The serial data line is resolved here from both output enables; idle high.
`timescale 1ns/10ps
`default_nettype none
interface aeoc_link_if;
  logic incA;
  logic incB;
  logic incI;
  logic pwmOut;
  logic fieldHighOrProgErrorFlag;
  logic fieldLowOrProgDoneFlag;
  logic alignSelect;
  logic powerDownSelect;
  logic programEnableInput;
  logic serialStrobeN;
  logic serialClock;
  logic sdDevOut;
  logic sdDevOe;
  logic sdHostOut;
  logic sdHostOe;
  logic serialDataBidir;
  assign serialDataBidir = sdDevOe ? sdDevOut : (sdHostOe ? sdHostOut : 1'b1);
  modport device(
    output incA, incB, incI, pwmOut, fieldHighOrProgErrorFlag, fieldLowOrProgDoneFlag,
    output sdDevOut, sdDevOe,
    input alignSelect, powerDownSelect, programEnableInput, serialStrobeN, serialClock,
    input serialDataBidir
  );
  modport host(
    input incA, incB, incI, pwmOut, fieldHighOrProgErrorFlag, fieldLowOrProgDoneFlag,
    input sdDevOut, sdDevOe,
    output alignSelect, powerDownSelect, programEnableInput, serialStrobeN, serialClock,
    output sdHostOut, sdHostOe,
    input serialDataBidir
  );
endinterface
`default_nettype wire

// *** inc/aeoc_pkg.sv ***
// Shared constants of the angle encoder output control: timing, configuration
// word layout, controller register map.
// Assumes a 100 MHz core clock on both ends of the link.
package aeoc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int LINK_HALF_NS = 80;
  localparam int LINK_HALF_CYC = LINK_HALF_NS / CLK_NS;
  localparam int FRAME_IDLE_NS = 2000;
  localparam int FRAME_IDLE_CYC = (FRAME_IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_GAP_NS = 3000;
  localparam int HOST_GAP_CYC = (HOST_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWM_BITS = 12;
  // ----------------------------------------------------------------
  // One-time-programmable configuration word
  // ----------------------------------------------------------------
  localparam int CFG_W = 26;
  localparam int CFG_ZERO_LSB = 0;
  localparam int CFG_DIR_BIT = 16;
  localparam int CFG_RES_LSB = 17;
  localparam int CFG_UVW_BIT = 20;
  localparam int CFG_IDX_LSB = 21;
  localparam int CFG_ABSHI_BIT = 23;
  localparam int CFG_FAST_BIT = 24;
  localparam int CFG_TWOWIRE_BIT = 25;
  localparam logic [25:0] CFG_RESET = 26'h00e0000;
  // ----------------------------------------------------------------
  // Controller registers
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PROGDATA = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_ANGLE = 4'hc;
  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_PROGRAM_ENABLE_INPUT_BIT = 1;
  localparam int CTRL_ALIGN_BIT = 2;
  localparam int CTRL_PD_BIT = 3;
  localparam int CTRL_PEN_BIT = 4;
  localparam int CTRL_TWOWIRE_BIT = 5;
  localparam int CTRL_NBITS_LSB = 8;
  localparam logic [4:0] NBITS_RESET = 5'h10;
endpackage

// *** verif/aeoc_link_assertions.sv ***
// Concurrent checks on the pins between the encoder device and its host.
// Assumes the signals of one aeoc_link_if and the shared core clock.
`timescale 1ns/10ps
`default_nettype none
module aeoc_link_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Device outputs
  input wire logic incA,
  input wire logic incB,
  input wire logic incI,
  input wire logic pwmOut,
  input wire logic sdDevOut,
  input wire logic sdDevOe,
  // Host outputs
  input wire logic powerDownSelect,
  input wire logic programEnableInput,
  input wire logic serialStrobeN,
  input wire logic serialClock,
  input wire logic sdHostOe
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_idle_released: assert property (serialStrobeN [*8] |-> !sdDevOe)
    else $error("device drives data line with strobe idle");
  a_program_enable_input_listens: assert property (programEnableInput [*8] |-> !sdDevOe)
    else $error("device drives data line while programming");
  a_no_contention: assert property (!(sdDevOe && sdHostOe))
    else $error("both ends drive the data line");
  a_read_host_quiet: assert property (!programEnableInput && !serialStrobeN |-> !sdHostOe)
    else $error("host drives data line in a read frame");
  a_power_quiet: assert property (powerDownSelect [*8] |-> !incA && !incB && !incI && !pwmOut)
    else $error("outputs active in power-down");
  a_clock_idle: assert property (serialStrobeN [*8] |-> serialClock)
    else $error("link clock not idle high outside frame");
  a_half_period: assert property ($fell(serialClock) |-> !serialClock [*8] ##1 serialClock)
    else $error("link clock low phase not eight cycles");
  a_bit_holds: assert property ($fell(serialClock) && sdDevOe |-> $stable(sdDevOut) [*6])
    else $error("data bit changes around host sample");

  c_read: cover property ($fell(serialStrobeN) && !programEnableInput);
  c_program_enable_input: cover property ($fell(serialStrobeN) && programEnableInput);
  c_power: cover property ($rose(powerDownSelect));
endmodule
`default_nettype wire

// *** verif/aeoc_test.sv ***
// Self-checking bench: host controller and encoder device joined by the link.
// Assumes the package, the interface and both design ends are compiled first.
`timescale 1ns/10ps
`default_nettype none
module aeoc_test;
  logic clk, rst_n, wrEn, rdEn, fieldHighFlag, fieldLowFlag, powerDown;
  logic [3:0] addr;
  logic [31:0] wrData, rdData, ctl, d;
  logic [15:0] angleRaw, fieldMag;
  logic [25:0] cfgActive;
  int nFail, checked, cyc;

  aeoc_link_if link();
  aeoc_device aeoc_device_inst (.clk(clk), .rst_n(rst_n), .link(link), .angleRaw(angleRaw),
    .fieldMag(fieldMag), .fieldHighFlag(fieldHighFlag), .fieldLowFlag(fieldLowFlag),
    .cfgActive(cfgActive), .powerDown(powerDown));
  aeoc_host aeoc_host_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .link(link));
  aeoc_link_assertions aeoc_link_assertions_inst (.clk(clk), .rst_n(rst_n),
    .incA(link.incA), .incB(link.incB), .incI(link.incI), .pwmOut(link.pwmOut),
    .sdDevOut(link.sdDevOut), .sdDevOe(link.sdDevOe), .powerDownSelect(link.powerDownSelect),
    .programEnableInput(link.programEnableInput), .serialStrobeN(link.serialStrobeN),
    .serialClock(link.serialClock), .sdHostOe(link.sdHostOe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      nFail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wrData <= v;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    @(posedge clk);
    d = rdData;
  endtask

  // Pins pass synchronisers on the far end, so give them time to land.
  task automatic setCtl(input logic [31:0] v);
    ctl = v;
    wr(aeoc_pkg::REG_CTRL, v);
    repeat (10) @(posedge clk);
  endtask

  // Busy appears a cycle after the start write, so polling waits first.
  task automatic frame(input logic [31:0] start);
    wr(aeoc_pkg::REG_CTRL, ctl | start);
    repeat (4) @(posedge clk);
    for (int i = 0; i < 3000; i++) begin
      rd(aeoc_pkg::REG_STATUS);
      if (d[0] === 1'b0) break;
    end
    chk("busy", d[0], 1'b0);
    repeat (10) @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tReset;
    chk("cfg", cfgActive, aeoc_pkg::CFG_RESET);
    chk("idle", {link.serialStrobeN, link.serialClock}, 2'b11);
    rd(aeoc_pkg::REG_CTRL);
    chk("ctrl", d, 32'h00001000);
    wr(4'h2, 32'hffffffff);
    rd(4'h2);
    chk("unmapped", d, 32'h0);
    $display("test reset done");
  endtask

  task automatic tRead(input logic [15:0] exp);
    frame(32'h1);
    rd(aeoc_pkg::REG_ANGLE);
    chk("angle", d, {16'h0, exp});
    $display("test read done");
  endtask

  task automatic tFlags;
    fieldHighFlag <= 1'b1;
    repeat (10) @(posedge clk);
    chk("fhigh", link.fieldHighOrProgErrorFlag, 1'b1);
    rd(aeoc_pkg::REG_STATUS);
    chk("status", d[5:4], 2'b01);
    fieldHighFlag <= 1'b0;
    fieldLowFlag <= 1'b1;
    repeat (10) @(posedge clk);
    chk("flow", {link.fieldHighOrProgErrorFlag, link.fieldLowOrProgDoneFlag}, 2'b01);
    fieldLowFlag <= 1'b0;
    repeat (10) @(posedge clk);
    $display("test flags done");
  endtask

  task automatic tPower;
    setCtl(ctl | 32'h8);
    chk("pd", {powerDown, link.incA, link.incB, link.incI, link.pwmOut}, 5'h10);
    setCtl(ctl & ~32'h8);
    $display("test power done");
  endtask

  task automatic tProg;
    wr(aeoc_pkg::REG_PROGDATA, 32'h00800000);
    setCtl(ctl | 32'h10);
    frame(32'h2);
    chk("done", {link.fieldHighOrProgErrorFlag, link.fieldLowOrProgDoneFlag}, 2'b01);
    chk("cfgnew", cfgActive, 26'h0800000);
    wr(aeoc_pkg::REG_PROGDATA, 32'h00100000);
    frame(32'h2);
    chk("err", link.fieldHighOrProgErrorFlag, 1'b1);
    chk("cfgkept", cfgActive, 26'h0800000);
    setCtl(ctl & ~32'h10);
    chk("clr", {link.fieldHighOrProgErrorFlag, link.fieldLowOrProgDoneFlag}, 2'b00);
    $display("test program done");
  endtask

  task automatic tWide;
    int n;
    n = 0;
    angleRaw <= 16'hb5c3;
    tRead(16'hb5c3);
    fieldMag <= 16'h3a5e;
    setCtl(ctl | 32'h4);
    tRead(16'h3a5e);
    setCtl(ctl & ~32'h4);
    angleRaw <= 16'h4000;
    repeat (10) @(posedge clk);
    repeat (4096) begin
      @(posedge clk);
      n += (link.pwmOut === 1'b1);
    end
    chk("pwm", n, 32'd1024);
    $display("test wide done");
  endtask

  // Samples mid-quarter of two 8 CPR cycles; each cycle spans 8192 counts.
  task automatic tQuad;
    logic [2:0] s [8];
    int aHi, bHi, i0, i1;
    aHi = 0;
    bHi = 0;
    i0 = 0;
    i1 = 0;
    for (int k = 0; k < 8; k++) begin
      angleRaw <= 16'(k * 2048 + 1024);
      repeat (12) @(posedge clk);
      s[k] = {link.incA, link.incB, link.incI};
    end
    for (int k = 0; k < 8; k++) begin
      chk("step", $countones(s[k][2:1] ^ s[(k + 1) % 8][2:1]), 32'd1);
      aHi += s[k][2];
      bHi += s[k][1];
      if (k < 4) begin
        i0 += s[k][0];
        chk("period", s[k][2:1], s[k + 4][2:1]);
      end else begin
        i1 += s[k][0];
      end
    end
    chk("aHigh", aHi, 32'd4);
    chk("bHigh", bHi, 32'd4);
    chk("index0", i0, 32'd1);
    chk("index1", i1, 32'd0);
    $display("test quadrature done");
  endtask

  // A second reset clears the one-time store, so a new word can select the rarer modes.
  task automatic tComm;
    logic [17:0] commutation_mode;
    commutation_mode = 18'h0b5a5;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    ctl = 32'h00001000;
    wr(aeoc_pkg::REG_PROGDATA, 32'h03911235);
    setCtl(ctl | 32'h10);
    frame(32'h2);
    angleRaw <= 16'h1000;
    setCtl(32'h00001020);
    tRead(16'hddc8);
    for (int k = 0; k < 6; k++) begin
      angleRaw <= 16'(32'hedcb - k * 1365 - 683);
      repeat (12) @(posedge clk);
      chk("uvw", {link.incA, link.incB, link.incI}, commutation_mode[k * 3 +: 3]);
    end
    $display("test commutation done");
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      nFail++;
      results;
    end
  end

  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wrData = 32'h0;
    wrEn = 1'b0;
    rdEn = 1'b0;
    ctl = 32'h00001000;
    angleRaw = 16'hb5c3;
    fieldMag = 16'h0;
    fieldHighFlag = 1'b0;
    fieldLowFlag = 1'b0;
    nFail = 0;
    checked = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    tReset;
    tRead(16'hb5c0);
    tFlags;
    tPower;
    tProg;
    tWide;
    tQuad;
    tComm;
    results;
  end
endmodule
`default_nettype wire
